// ==== rdpc_map.vh ====
// Purpose: register offsets, fields, reset values and timing counts for the pin control block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: included by the debug bit engine, the pin controller and the bench; not by the synchroniser
`ifndef RDPC_MAP_VH
`define RDPC_MAP_VH

// register byte offsets
`define RDPC_SYS_OPT_ADDR 6'h00
`define RDPC_STATUS_ADDR 6'h04
`define RDPC_PORT_OUT_ADDR 6'h08
`define RDPC_PORT_DIR_ADDR 6'h0C
`define RDPC_PORT_PULL_ADDR 6'h10
`define RDPC_PORT_IN_ADDR 6'h14
`define RDPC_DBG_TX_ADDR 6'h18
`define RDPC_DBG_RX_ADDR 6'h1C

// system options fields
`define RDPC_OPT_DBG_PE 0
`define RDPC_OPT_RST_PE 1
`define RDPC_OPT_IRQ_PE 2
`define RDPC_OPT_CMP_OE 3
`define RDPC_OPT_RST_VAL 4'h3

// status fields
`define RDPC_ST_IRQ_LVL 0
`define RDPC_ST_BR_HIGH 1
`define RDPC_ST_BR_LOW 2
`define RDPC_ST_BGND 3
`define RDPC_ST_BUSY 4
`define RDPC_ST_RX_VLD 5

// debug bit timing
`define RDPC_BIT_CYCLES 16
`define RDPC_SPEEDUP_CYCLES 1
`define RDPC_DRIVE_ZERO_CYCLES 13
`define RDPC_DRIVE_ONE_CYCLES 4
`define RDPC_SAMPLE_CYCLE 10

`define RDPC_RESP_OKAY 2'h0
`define RDPC_RESP_SLVERR 2'h2

`endif

// ==== rdpc_sync.v ====
// Purpose: two-flop level synchroniser
// Assumes: single clock aclk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module rdpc_sync (
    aclk,
    aresetn,
    ce,
    async_in,
    sync_out
);
    input wire aclk;
    input wire aresetn;
    input wire ce;
    input wire async_in;
    output reg sync_out;

    reg meta_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 1'b1;
            sync_out <= 1'b1;
        end else if (ce) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // rdpc_sync

// ==== rdpc_dbg_bit.v ====
// Purpose: single-wire debug bit engine, one bit per 16 debug clock ticks
// Assumes: debug tick enable no faster than aclk
// Notes: pseudo open drain with a brief driven-high speedup pulse
`timescale 1ns/1ps
`include "rdpc_map.vh"
module rdpc_dbg_bit (
    aclk,
    aresetn,
    ce,
    dbg_tick,
    enable,
    start,
    tx_bit,
    line_in,
    busy,
    rx_bit,
    rx_valid,
    drive_low,
    drive_high
);
    input wire aclk;
    input wire aresetn;
    input wire ce;
    input wire dbg_tick;
    input wire enable;
    input wire start;
    input wire tx_bit;
    input wire line_in;
    output reg busy;
    output reg rx_bit;
    output reg rx_valid;
    output reg drive_low;
    output reg drive_high;

    reg [4:0] cnt_r;
    reg bit_r;
    wire [4:0] low_len;
    wire step;

    assign low_len = bit_r ? 5'd`RDPC_DRIVE_ONE_CYCLES : 5'd`RDPC_DRIVE_ZERO_CYCLES;
    assign step = ce && dbg_tick;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 5'h00;
            bit_r <= 1'b0;
            busy <= 1'b0;
            rx_bit <= 1'b0;
            rx_valid <= 1'b0;
            drive_low <= 1'b0;
            drive_high <= 1'b0;
        end else if (ce) begin
            rx_valid <= 1'b0;
            if (!enable) begin
                busy <= 1'b0;
                drive_low <= 1'b0;
                drive_high <= 1'b0;
                cnt_r <= 5'h00;
            end else if (!busy) begin
                drive_high <= 1'b0;
                if (start) begin
                    busy <= 1'b1;
                    bit_r <= tx_bit;
                    cnt_r <= 5'h00;
                    drive_low <= 1'b1;
                end
            end else if (step) begin
                cnt_r <= cnt_r + 5'h01;
                // low phase, then speedup pulse
                drive_low <= (cnt_r + 5'h01) < low_len;
                drive_high <= ((cnt_r + 5'h01) >= low_len) &&
                    ((cnt_r + 5'h01) < low_len + 5'd`RDPC_SPEEDUP_CYCLES);
                if (cnt_r == 5'd`RDPC_SAMPLE_CYCLE) begin
                    rx_bit <= line_in;
                end
                if (cnt_r == 5'd`RDPC_BIT_CYCLES - 5'h01) begin
                    busy <= 1'b0;
                    rx_valid <= 1'b1;
                    drive_low <= 1'b0;
                    drive_high <= 1'b0;
                end
            end
        end
    end
endmodule // rdpc_dbg_bit

// ==== rdpc_pin_ctrl.v ====
// Purpose: reset/interrupt pin, debug/mode pin and port pin control with AXI4-Lite registers
// Assumes: all inputs synchronous to aclk except irq_pin_in; por_n marks power-on reset
// Notes: pin output enables are active low
`timescale 1ns/1ps
`include "rdpc_map.vh"
module rdpc_pin_ctrl #(
    parameter PORT_W = 32,
    parameter OD_DATA_BIT = 2,
    parameter OD_CLK_BIT = 3,
    parameter DBG_PIN_BIT = 4,
    parameter RST_PIN_BIT = 5
) (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire por_n,
    input wire int_reset_req,
    input wire dbg_force_reset,
    input wire dbg_tick,
    input wire comparator_output,
    input wire irq_pin_in,
    input wire debug_mode_shared_pin_in,
    input wire [PORT_W-1:0] port_pins_in,
    output reg reset_interrupt_shared_pin_out,
    output reg reset_interrupt_shared_pin_oe_n,
    output reg reset_interrupt_shared_pin_pullup,
    output reg debug_mode_shared_pin_out,
    output reg debug_mode_shared_pin_oe_n,
    output reg debug_mode_shared_pin_pullup,
    output reg [PORT_W-1:0] port_pins_out,
    output reg [PORT_W-1:0] port_pins_oe_n,
    output reg [PORT_W-1:0] port_pins_pullup,
    output reg ext_reset_req,
    output reg ext_irq_req,
    output reg branch_if_int_pin_high,
    output reg branch_if_int_pin_low,
    output reg background_mode,
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // byte-lane merge used by the port output, direction and pullup registers
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer k;
        begin
            merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    merge[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction
    function is_mapped;
        input [5:0] a;
        begin
            is_mapped = (a[1:0] == 2'h0) && (a <= `RDPC_DBG_RX_ADDR);
        end
    endfunction
    reg [3:0] opt_r;
    reg [PORT_W-1:0] out_r;
    reg [PORT_W-1:0] dir_r;
    reg [PORT_W-1:0] pull_r;
    reg [PORT_W-1:0] in_r;
    reg mode_lo_r;
    reg in_reset_r;
    reg tx_start_r;
    reg tx_bit_r;
    reg rx_data_r;
    reg rx_vld_r;
    reg [5:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg aw_have_r;
    reg w_have_r;
    wire irq_sync;
    wire dbg_busy;
    wire dbg_rx_bit;
    wire dbg_rx_vld;
    wire dbg_drv_low;
    wire dbg_drv_high;
    wire sys_reset;
    wire [31:0] st_word;
    reg [31:0] rd_mux;
    reg [PORT_W-1:0] pin_out_nxt;
    reg [PORT_W-1:0] pin_oe_n_nxt;
    reg [PORT_W-1:0] pin_pull_nxt;
    wire wr_fire;
    wire [31:0] wr_data;
    integer i;
    assign sys_reset = !aresetn || int_reset_req || dbg_force_reset;
    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_data = wdata_r;
    rdpc_sync u_irq_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .async_in(irq_pin_in),
        .sync_out(irq_sync)
    );
    rdpc_dbg_bit u_dbg_bit (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .dbg_tick(dbg_tick),
        .enable(opt_r[`RDPC_OPT_DBG_PE] && !in_reset_r),
        .start(tx_start_r),
        .tx_bit(tx_bit_r),
        .line_in(debug_mode_shared_pin_in),
        .busy(dbg_busy),
        .rx_bit(dbg_rx_bit),
        .rx_valid(dbg_rx_vld),
        .drive_low(dbg_drv_low),
        .drive_high(dbg_drv_high)
    );
    assign st_word = {26'h0000000, rx_vld_r, dbg_busy, background_mode,
        branch_if_int_pin_low, branch_if_int_pin_high, irq_sync};
    // system options and reset state
    always @(posedge aclk) begin
        if (!por_n) begin
            opt_r <= `RDPC_OPT_RST_VAL;
            in_reset_r <= 1'b1;
            mode_lo_r <= !debug_mode_shared_pin_in;
        end else if (ce) begin
            in_reset_r <= sys_reset;
            if (sys_reset) begin
                opt_r[`RDPC_OPT_DBG_PE] <= 1'b1;
                mode_lo_r <= !debug_mode_shared_pin_in;
            end else if (wr_fire && awaddr_r == `RDPC_SYS_OPT_ADDR) begin
                opt_r <= wstrb_r[0] ? wr_data[3:0] : opt_r;
            end
        end
    end
    // mode select capture at reset release
    always @(posedge aclk) begin
        if (!aresetn) begin
            background_mode <= 1'b0;
        end else if (ce && in_reset_r && !sys_reset) begin
            background_mode <= mode_lo_r;
        end
    end
    // port registers and debug command registers
    always @(posedge aclk) begin
        if (!aresetn || !por_n) begin
            out_r <= {PORT_W{1'b0}};
            dir_r <= {PORT_W{1'b0}};
            pull_r <= {PORT_W{1'b0}};
            tx_start_r <= 1'b0;
            tx_bit_r <= 1'b0;
            rx_data_r <= 1'b0;
            rx_vld_r <= 1'b0;
            in_r <= {PORT_W{1'b0}};
        end else if (ce) begin
            in_r <= port_pins_in;
            tx_start_r <= 1'b0;
            if (wr_fire) begin
                case (awaddr_r)
                    `RDPC_PORT_OUT_ADDR: out_r <= merge(out_r, wr_data, wstrb_r);
                    `RDPC_PORT_DIR_ADDR: dir_r <= merge(dir_r, wr_data, wstrb_r);
                    `RDPC_PORT_PULL_ADDR: pull_r <= merge(pull_r, wr_data, wstrb_r);
                    `RDPC_DBG_TX_ADDR: begin
                        tx_bit_r <= wr_data[0];
                        tx_start_r <= wstrb_r[0];
                    end
                    default: begin
                    end
                endcase
            end
            if (dbg_rx_vld) begin
                rx_data_r <= dbg_rx_bit;
                rx_vld_r <= 1'b1;
            end else if (s_axi_arready && s_axi_arvalid && s_axi_araddr == `RDPC_DBG_RX_ADDR) begin
                rx_vld_r <= 1'b0;
            end
        end
    end
    // port pin drive
    always @* begin
        for (i = 0; i < PORT_W; i = i + 1) begin
            pin_out_nxt[i] = out_r[i];
            pin_oe_n_nxt[i] = !dir_r[i];
            pin_pull_nxt[i] = pull_r[i] && !dir_r[i];
            if (i == OD_DATA_BIT || i == OD_CLK_BIT) begin
                pin_out_nxt[i] = 1'b0;
                pin_oe_n_nxt[i] = !(dir_r[i] && !out_r[i]);
                pin_pull_nxt[i] = pull_r[i] && !(dir_r[i] && !out_r[i]);
            end
            if (i == DBG_PIN_BIT || i == RST_PIN_BIT) begin
                pin_oe_n_nxt[i] = 1'b1;
                pin_pull_nxt[i] = 1'b0;
            end
        end
    end
    // pin outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            port_pins_out <= {PORT_W{1'b0}};
            port_pins_oe_n <= {PORT_W{1'b1}};
            port_pins_pullup <= {PORT_W{1'b0}};
            reset_interrupt_shared_pin_out <= 1'b0;
            reset_interrupt_shared_pin_oe_n <= 1'b0;
            reset_interrupt_shared_pin_pullup <= 1'b1;
            debug_mode_shared_pin_out <= 1'b1;
            debug_mode_shared_pin_oe_n <= 1'b1;
            debug_mode_shared_pin_pullup <= 1'b1;
            ext_reset_req <= 1'b0;
            ext_irq_req <= 1'b0;
            branch_if_int_pin_high <= 1'b0;
            branch_if_int_pin_low <= 1'b0;
        end else if (ce) begin
            port_pins_out <= pin_out_nxt;
            port_pins_oe_n <= pin_oe_n_nxt;
            port_pins_pullup <= pin_pull_nxt;
            // shared reset pin
            reset_interrupt_shared_pin_out <= 1'b0;
            reset_interrupt_shared_pin_oe_n <= !(sys_reset && opt_r[`RDPC_OPT_RST_PE]);
            reset_interrupt_shared_pin_pullup <= opt_r[`RDPC_OPT_RST_PE] ||
                (opt_r[`RDPC_OPT_IRQ_PE] && pull_r[RST_PIN_BIT]);
            ext_reset_req <= opt_r[`RDPC_OPT_RST_PE] && !irq_sync;
            ext_irq_req <= !opt_r[`RDPC_OPT_RST_PE] && opt_r[`RDPC_OPT_IRQ_PE] && !irq_sync;
            branch_if_int_pin_high <= !opt_r[`RDPC_OPT_RST_PE] && opt_r[`RDPC_OPT_IRQ_PE] && irq_sync;
            branch_if_int_pin_low <= !opt_r[`RDPC_OPT_RST_PE] && opt_r[`RDPC_OPT_IRQ_PE] && !irq_sync;
            // shared debug pin
            if (in_reset_r) begin
                debug_mode_shared_pin_out <= 1'b1;
                debug_mode_shared_pin_oe_n <= 1'b1;
                debug_mode_shared_pin_pullup <= 1'b1;
            end else if (opt_r[`RDPC_OPT_DBG_PE]) begin
                debug_mode_shared_pin_out <= dbg_drv_high;
                debug_mode_shared_pin_oe_n <= !(dbg_drv_low || dbg_drv_high);
                debug_mode_shared_pin_pullup <= 1'b1;
            end else begin
                debug_mode_shared_pin_out <= opt_r[`RDPC_OPT_CMP_OE] ? comparator_output : out_r[DBG_PIN_BIT];
                debug_mode_shared_pin_oe_n <= 1'b0;
                debug_mode_shared_pin_pullup <= 1'b0;
            end
        end
    end
    // read mux
    always @* begin
        case (s_axi_araddr)
            `RDPC_SYS_OPT_ADDR: rd_mux = {28'h0000000, opt_r};
            `RDPC_STATUS_ADDR: rd_mux = st_word;
            `RDPC_PORT_OUT_ADDR: rd_mux = out_r;
            `RDPC_PORT_DIR_ADDR: rd_mux = dir_r;
            `RDPC_PORT_PULL_ADDR: rd_mux = pull_r;
            `RDPC_PORT_IN_ADDR: rd_mux = in_r;
            `RDPC_DBG_RX_ADDR: rd_mux = {31'h00000000, rx_data_r};
            default: rd_mux = 32'h00000000;
        endcase
    end
    // AXI4-Lite slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RDPC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RDPC_RESP_OKAY;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 6'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else if (ce) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            if (s_axi_awvalid && !aw_have_r && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
            end
            if (s_axi_wvalid && !w_have_r && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (is_mapped(awaddr_r) && awaddr_r != `RDPC_STATUS_ADDR &&
                    awaddr_r != `RDPC_PORT_IN_ADDR && awaddr_r != `RDPC_DBG_RX_ADDR) ?
                    `RDPC_RESP_OKAY : `RDPC_RESP_SLVERR;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? `RDPC_RESP_OKAY : `RDPC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // rdpc_pin_ctrl

// ==== rdpc_host_model.sv ====
// Purpose: board and debug host seen at the reset and debug pins
// Assumes: board pullups on both lines
// Notes: device drive wins over host hold
`timescale 1ns/1ps
module rdpc_host_model (
    input wire rst_oe_n,
    input wire rst_out,
    input wire switch_low,
    input wire dbg_oe_n,
    input wire dbg_out,
    input wire hold_ms,
    output wire rst_level,
    output wire dbg_level
);
    // manual reset switch to ground
    assign rst_level = !rst_oe_n ? rst_out : !switch_low;
    // host holds mode select low through reset
    assign dbg_level = !dbg_oe_n ? dbg_out : !hold_ms;
endmodule // rdpc_host_model

// ==== rdpc_pin_ctrl_properties.sv ====
// Purpose: port checks of the pin control block
// Assumes: ce held high
// Notes: attached by bind
`timescale 1ns/1ps
module rdpc_pin_ctrl_properties #(
    parameter PORT_W = 32
) (
    input wire aclk,
    input wire aresetn,
    input wire irq_pin_in,
    input wire reset_interrupt_shared_pin_out,
    input wire debug_mode_shared_pin_out,
    input wire debug_mode_shared_pin_oe_n,
    input wire [PORT_W-1:0] port_pins_out,
    input wire [PORT_W-1:0] port_pins_oe_n,
    input wire [PORT_W-1:0] port_pins_pullup,
    input wire ext_irq_req,
    input wire branch_if_int_pin_high,
    input wire branch_if_int_pin_low,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    localparam [PORT_W-1:0] OD_M = 32'h0000000C;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rst_pin_low: assert property (reset_interrupt_shared_pin_out == 1'b0)
        else $error("reset pin driven high");
    a_od_data_low: assert property (!port_pins_oe_n[2] |-> !port_pins_out[2])
        else $error("data pin driven high");
    a_od_clk_low: assert property (!port_pins_oe_n[3] |-> !port_pins_out[3])
        else $error("clock pin driven high");
    a_pull_on_output: assert property ((~port_pins_oe_n & port_pins_pullup & ~OD_M) == '0)
        else $error("pullup on driven pin");
    a_branch_excl: assert property (!(branch_if_int_pin_high && branch_if_int_pin_low))
        else $error("both branch conditions");
    a_irq_two_flop: assert property ($changed(irq_pin_in) |=> $stable(ext_irq_req))
        else $error("irq level used unsynchronised");
    a_dbg_speedup: assert property ($past(!debug_mode_shared_pin_oe_n && !debug_mode_shared_pin_out)
        && (debug_mode_shared_pin_oe_n || debug_mode_shared_pin_out)
        |-> !debug_mode_shared_pin_oe_n && debug_mode_shared_pin_out)
        else $error("no speedup pulse");
    a_write_answer: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
        else $error("read answer late");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held after take");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid held after take");
endmodule // rdpc_pin_ctrl_properties
bind rdpc_pin_ctrl rdpc_pin_ctrl_properties #(.PORT_W(PORT_W)) u_rdpc_pin_ctrl_properties (.*);

// ==== rdpc_pin_ctrl_tb.sv ====
// Purpose: self-checking bench for the pin control block
// Assumes: ce and dbg_tick held high
// Notes: pins resolved by rdpc_host_model
`timescale 1ns/1ps
`include "rdpc_map.vh"
module rdpc_pin_ctrl_tb;
    localparam logic [5:0] A_OPT = `RDPC_SYS_OPT_ADDR;
    localparam logic [5:0] A_TX = `RDPC_DBG_TX_ADDR;
    localparam logic [1:0] OK = `RDPC_RESP_OKAY;
    localparam logic [1:0] ERR = `RDPC_RESP_SLVERR;
    logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, ce = 1'b1, dbg_tick = 1'b1, dbg_force_reset = 1'b0;
    logic int_reset_req = 1'b0, comparator_output = 1'b0, sw_low = 1'b0, hold_ms = 1'b0, spd;
    logic irq_pin_in, debug_mode_shared_pin_in, ext_reset_req, ext_irq_req, background_mode;
    logic reset_interrupt_shared_pin_out, reset_interrupt_shared_pin_oe_n, reset_interrupt_shared_pin_pullup;
    logic debug_mode_shared_pin_out, debug_mode_shared_pin_oe_n, debug_mode_shared_pin_pullup;
    logic branch_if_int_pin_high, branch_if_int_pin_low;
    logic [31:0] port_pins_in = 32'h0, port_pins_out, port_pins_oe_n, port_pins_pullup;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_fail = 0, checks_done = 0, run = 0, last_run = 0;
    rdpc_pin_ctrl u_rdpc_pin_ctrl (.*);
    rdpc_host_model u_rdpc_host_model (
        .rst_oe_n(reset_interrupt_shared_pin_oe_n),
        .rst_out(reset_interrupt_shared_pin_out),
        .switch_low(sw_low),
        .dbg_oe_n(debug_mode_shared_pin_oe_n),
        .dbg_out(debug_mode_shared_pin_out),
        .hold_ms(hold_ms),
        .rst_level(irq_pin_in),
        .dbg_level(debug_mode_shared_pin_in)
    );
    initial begin
        forever #2.5 aclk = ~aclk;
    end
    // length of each driven-low run and the cycle after it
    always @(posedge aclk) begin
        if (!debug_mode_shared_pin_oe_n && !debug_mode_shared_pin_out) begin
            run <= run + 1;
        end else begin
            if (run != 0) begin
                last_run <= run;
                spd <= !debug_mode_shared_pin_oe_n && debug_mode_shared_pin_out;
            end
            run <= 0;
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'({s_axi_bvalid, s_axi_bresp}), 32'({1'b1, er}));
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_rvalid && n < 50);
        chk("rvalid", 32'(s_axi_rvalid), 32'h1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, d, e);
        chk("rresp", 32'(r), 32'(er));
    endtask
    task automatic do_reset(input logic por);
        @(posedge aclk);
        aresetn <= 1'b0;
        por_n <= !por;
        cyc(3);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        cyc(1);
    endtask
    task automatic t_after_reset();
        chk("port oe_n", port_pins_oe_n, 32'hFFFFFFFF);
        chk("port pull", port_pins_pullup, 32'h0);
        chk("rst pull", 32'(reset_interrupt_shared_pin_pullup), 32'h1);
        chk("bgnd", 32'(background_mode), 32'h0);
        rchk("opts", A_OPT, 32'h3, OK);
    endtask
    task automatic t_rst_drive();
        @(posedge aclk);
        int_reset_req <= 1'b1;
        cyc(5);
        chk("rst oe_n", 32'(reset_interrupt_shared_pin_oe_n), 32'h0);
        chk("ext rst", 32'(ext_reset_req), 32'h1);
        int_reset_req <= 1'b0;
        cyc(4);
        chk("rst oe_n off", 32'(reset_interrupt_shared_pin_oe_n), 32'h1);
    endtask
    task automatic t_bgnd();
        @(posedge aclk);
        hold_ms <= 1'b1;
        aresetn <= 1'b0;
        por_n <= 1'b0;
        cyc(3);
        chk("ms pull", 32'(debug_mode_shared_pin_pullup), 32'h1);
        chk("ms oe_n", 32'(debug_mode_shared_pin_oe_n), 32'h1);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        cyc(4);
        hold_ms <= 1'b0;
        cyc(2);
        chk("bgnd", 32'(background_mode), 32'h1);
        dbg_force_reset <= 1'b1;
        cyc(3);
        dbg_force_reset <= 1'b0;
        cyc(3);
        chk("bgnd force", 32'(background_mode), 32'h0);
    endtask
    task automatic t_keep_opts();
        wr(A_OPT, 32'h0, OK);
        do_reset(1'b0);
        rchk("opts warm", A_OPT, 32'h1, OK);
        int_reset_req <= 1'b1;
        cyc(4);
        chk("rst fn off", 32'(reset_interrupt_shared_pin_oe_n), 32'h1);
        int_reset_req <= 1'b0;
        do_reset(1'b1);
        rchk("opts por", A_OPT, 32'h3, OK);
    endtask
    task automatic t_irq();
        wr(A_OPT, 32'h4, OK);
        sw_low <= 1'b1;
        cyc(6);
        chk("bil", 32'(branch_if_int_pin_low), 32'h1);
        chk("irq req", 32'(ext_irq_req), 32'h1);
        rchk("st low", `RDPC_STATUS_ADDR, 32'h4, OK);
        sw_low <= 1'b0;
        cyc(6);
        chk("bih", 32'(branch_if_int_pin_high), 32'h1);
        rchk("st high", `RDPC_STATUS_ADDR, 32'h3, OK);
    endtask
    task automatic t_port();
        comparator_output <= 1'b1;
        wr(A_OPT, 32'h8, OK);
        wr(`RDPC_PORT_DIR_ADDR, 32'h0000FF0F, OK);
        wr(`RDPC_PORT_PULL_ADDR, 32'hF0F0F0FF, OK);
        wr(`RDPC_PORT_OUT_ADDR, 32'h00000F06, OK);
        cyc(3);
        chk("pullups", port_pins_pullup & 32'hFFFFFFC3, 32'hF0F000C0);
        chk("oe_n", port_pins_oe_n, 32'hFFFF00F4);
        chk("outs", port_pins_out & 32'h0000FF0B, 32'h00000F02);
        chk("cmp pin", 32'({debug_mode_shared_pin_oe_n, debug_mode_shared_pin_pullup, debug_mode_shared_pin_out}),
            32'h1);
        wr(`RDPC_PORT_IN_ADDR, 32'h0, ERR);
        rchk("unmapped", 6'h20, 32'h0, ERR);
        wr(A_OPT, 32'h9, OK);
        cyc(3);
        chk("pin held", 32'(debug_mode_shared_pin_oe_n), 32'h1);
    endtask
    task automatic t_dbg();
        logic [31:0] d;
        logic [1:0] r;
        wr(A_OPT, 32'h1, OK);
        wr(A_TX, 32'h0, OK);
        cyc(24);
        chk("zero run", last_run, `RDPC_DRIVE_ZERO_CYCLES);
        chk("speedup", 32'(spd), 32'h1);
        rchk("rx zero", `RDPC_DBG_RX_ADDR, 32'h0, OK);
        wr(A_TX, 32'h1, OK);
        cyc(24);
        chk("one run", last_run, `RDPC_DRIVE_ONE_CYCLES);
        rchk("rx one", `RDPC_DBG_RX_ADDR, 32'h1, OK);
        wr(A_OPT, 32'h8, OK);
        wr(A_TX, 32'h1, OK);
        cyc(24);
        rd(A_ST_ADDR(), d, r);
        chk("no bit", d & 32'h30, 32'h0);
    endtask
    function automatic logic [5:0] A_ST_ADDR();
        return `RDPC_STATUS_ADDR;
    endfunction
    initial begin
        #50000;
        n_fail++;
        final_report();
    end
    initial begin
        cyc(3);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        cyc(1);
        t_after_reset();
        t_rst_drive();
        t_bgnd();
        do_reset(1'b1);
        t_after_reset();
        t_keep_opts();
        t_irq();
        t_port();
        t_dbg();
        final_report();
    end
endmodule // rdpc_pin_ctrl_tb
